// file: isg_defs.vh
// constants for the idle, standby timer and geometry command block
`ifndef ISG_DEFS_VH
`define ISG_DEFS_VH

// register offsets (byte addresses)
`define ISG_OFF_SECCNT 8'h00
`define ISG_OFF_DEVHEAD 8'h04
`define ISG_OFF_COMMAND 8'h08
`define ISG_OFF_ERROR 8'h0c
`define ISG_OFF_STATUS 8'h10
`define ISG_OFF_GEOMETRY 8'h14
`define ISG_OFF_TIMER 8'h18
`define ISG_OFF_IRQ_STATUS 8'h1c
`define ISG_OFF_IRQ_MASK 8'h20
`define ISG_OFF_DEFAULTS 8'h24
`define ISG_OFF_POWER 8'h28
`define ISG_OFF_ID_INDEX 8'h2c
`define ISG_OFF_ID_DATA 8'h30

// command codes
`define ISG_CMD_IDLE_A 8'he3
`define ISG_CMD_IDLE_B 8'h97
`define ISG_CMD_IDLE_IMM_A 8'he1
`define ISG_CMD_IDLE_IMM_B 8'h95
`define ISG_CMD_INIT_PARAMS 8'h91

// error and status bit positions
`define ISG_ERR_ABORT_BIT 2
`define ISG_ST_BSY_BIT 7
`define ISG_ST_RDY_BIT 6
`define ISG_ST_DSC_BIT 4
`define ISG_ST_ERR_BIT 0

// interrupt status bits
`define ISG_IRQ_DONE_BIT 0
`define ISG_IRQ_ABORT_BIT 1
`define ISG_IRQ_STANDBY_BIT 2
`define ISG_IRQ_WIDTH 3

// reset-defaults option codes
`define ISG_OPT_REVERT 8'hcc
`define ISG_OPT_KEEP 8'h66
`define ISG_RST_OPTION 8'h66

// geometry reset values and identify word numbers
`define ISG_DEF_SPT 8'h3f
`define ISG_DEF_HEADS_M1 4'hf
`define ISG_CUR_CYLS 16'h0fff
`define ISG_ID_WORD_CYLS 8'd54
`define ISG_ID_WORD_HEADS 8'd55
`define ISG_ID_WORD_SPT 8'd56
`define ISG_ID_WORD_CAP_LO 8'd57
`define ISG_ID_WORD_CAP_HI 8'd58

// timeout encodings, in seconds
`define ISG_TO_DISABLED 8'd0
`define ISG_TO_SHORT_MAX 8'd240
`define ISG_TO_LONG_MAX 8'd251
`define ISG_TO_21MIN 8'd252
`define ISG_TO_8H 8'd253
`define ISG_TO_ABORT 8'd254
`define ISG_TO_21MIN15 8'd255
`define ISG_STEP_SHORT_S 16'd5
`define ISG_STEP_LONG_S 16'd1800
`define ISG_LONG_BASE 16'd240
`define ISG_21MIN_S 16'd1260
`define ISG_8H_S 16'd28800
`define ISG_21MIN15_S 16'd1275

// core clock cycles in one second at 25 MHz
`define ISG_SEC_CYCLES 25'd25000000

`endif

// file: isg_cmd_block.v
// idle, idle immediate and device geometry command handling with standby timer
`timescale 1ns/1ps
`include "isg_defs.vh"

module isg_cmd_block #(
  parameter [24:0] SEC_CYCLES = `ISG_SEC_CYCLES
) (
  input wire core_clk,
  input wire reset,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire spindle_rotating,
  input wire soft_reset,
  output reg spin_up_req,
  output reg spin_down_req,
  output reg idle_mode,
  output reg standby_mode,
  output reg irq
);

  localparam ST_READY = 1'b0;
  localparam ST_EXEC = 1'b1;

  // task file written by the host
  reg [7:0] sector_count;
  reg [7:0] device_head;
  reg [7:0] command;
  reg state;
  reg busy;
  reg command_aborted_flag;
  reg err;

  // geometry
  reg [7:0] sectors_per_track;
  reg [3:0] heads_minus_one;
  reg [7:0] defaults_option;

  // standby timer
  reg [7:0] timeout_code;
  reg [15:0] interval_s;
  reg [15:0] remaining_s;
  reg [24:0] tick_count;
  reg sec_tick;

  // interrupts and identify access
  wire [`ISG_IRQ_WIDTH-1:0] irq_status;
  reg [`ISG_IRQ_WIDTH-1:0] irq_mask;
  reg [7:0] id_index;

  // two-flop synchronisers for pins: bit 0 spindle, bit 1 soft reset
  wire [1:0] pin_in = {soft_reset, spindle_rotating};
  wire [1:0] pin_sync;
  wire spin_sync = pin_sync[0];
  wire srst_sync = pin_sync[1];
  reg srst_prev;

  wire host_access = bus_wr | bus_rd;
  wire cmd_write = bus_wr && (bus_addr == `ISG_OFF_COMMAND);
  wire soft_reset_rise = srst_sync & ~srst_prev;

  // decode of the sector count timeout parameter into seconds
  function [15:0] decode_timeout;
    input [7:0] code;
    reg [15:0] wide;
    begin
      wide = {8'h00, code};
      if (code == `ISG_TO_DISABLED) begin
        decode_timeout = 16'h0000;
      end else if (code <= `ISG_TO_SHORT_MAX) begin
        decode_timeout = wide * `ISG_STEP_SHORT_S;
      end else if (code <= `ISG_TO_LONG_MAX) begin
        decode_timeout = (wide - `ISG_LONG_BASE) * `ISG_STEP_LONG_S;
      end else if (code == `ISG_TO_21MIN) begin
        decode_timeout = `ISG_21MIN_S;
      end else if (code == `ISG_TO_8H) begin
        decode_timeout = `ISG_8H_S;
      end else begin
        decode_timeout = `ISG_21MIN15_S;
      end
    end
  endfunction

  // pin synchronisers; only the second flop of each pair is read
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : gen_pin_sync
      reg meta;
      reg held;
      always @(posedge core_clk) begin
        if (reset) begin
          meta <= 1'b0;
          held <= 1'b0;
        end else begin
          meta <= pin_in[p];
          held <= meta;
        end
      end
      assign pin_sync[p] = held;
    end
  endgenerate

  // edge detector starts low, the idle level of the soft reset pin
  always @(posedge core_clk) begin
    if (reset) begin
      srst_prev <= 1'b0;
    end else begin
      srst_prev <= srst_sync;
    end
  end

  // one-second tick from the core clock
  // free running, so the first second after a load may be short
  always @(posedge core_clk) begin
    if (reset) begin
      tick_count <= 25'h0000000;
      sec_tick <= 1'b0;
    end else if (tick_count == SEC_CYCLES - 25'h0000001) begin
      tick_count <= 25'h0000000;
      sec_tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 25'h0000001;
      sec_tick <= 1'b0;
    end
  end

  // task file writes and the command engine
  wire is_idle = (command == `ISG_CMD_IDLE_A) || (command == `ISG_CMD_IDLE_B);
  wire is_idle_imm = (command == `ISG_CMD_IDLE_IMM_A) || (command == `ISG_CMD_IDLE_IMM_B);
  wire is_init = (command == `ISG_CMD_INIT_PARAMS);
  wire bad_timeout = is_idle && (sector_count == `ISG_TO_ABORT);
  wire cmd_reject = bad_timeout || !(is_idle || is_idle_imm || is_init);
  wire exec_now = (state == ST_EXEC);
  wire enter_idle = exec_now && !cmd_reject && (is_idle || is_idle_imm);
  wire load_timer = exec_now && !cmd_reject && is_idle;
  wire standby_armed = idle_mode && (interval_s != 16'h0000);
  wire timer_expire = standby_armed && sec_tick && (remaining_s == 16'h0001) && !host_access;
  // a strobe on the last tick still restarts the full interval
  wire timer_reload = standby_armed && host_access;
  wire timer_step = standby_armed && sec_tick && (remaining_s != 16'h0000);

  always @(posedge core_clk) begin
    if (reset) begin
      sector_count <= 8'h00;
      device_head <= 8'h00;
      command <= 8'h00;
      state <= ST_READY;
      busy <= 1'b0;
      command_aborted_flag <= 1'b0;
      err <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == `ISG_OFF_SECCNT && !busy) begin
        sector_count <= bus_wdata[7:0];
      end
      if (bus_wr && bus_addr == `ISG_OFF_DEVHEAD && !busy) begin
        device_head <= bus_wdata[7:0];
      end
      case (state)
        ST_READY: begin
          // a command written while busy is ignored; the host waits on bsy
          if (cmd_write) begin
            command <= bus_wdata[7:0];
            busy <= 1'b1;
            command_aborted_flag <= 1'b0;
            err <= 1'b0;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          busy <= 1'b0;
          command_aborted_flag <= cmd_reject;
          err <= cmd_reject;
          state <= ST_READY;
        end
        default: begin
          state <= ST_READY;
        end
      endcase
    end
  end

  // geometry, kept across soft reset unless the revert option is chosen
  always @(posedge core_clk) begin
    if (reset) begin
      sectors_per_track <= `ISG_DEF_SPT;
      heads_minus_one <= `ISG_DEF_HEADS_M1;
      defaults_option <= `ISG_RST_OPTION;
    end else begin
      if (bus_wr && bus_addr == `ISG_OFF_DEFAULTS) begin
        defaults_option <= bus_wdata[7:0];
      end
      if (exec_now && is_init) begin
        sectors_per_track <= sector_count;
        heads_minus_one <= device_head[3:0];
      end else if (soft_reset_rise && defaults_option == `ISG_OPT_REVERT) begin
        sectors_per_track <= `ISG_DEF_SPT;
        heads_minus_one <= `ISG_DEF_HEADS_M1;
      end
    end
  end

  // power modes and the standby timer
  always @(posedge core_clk) begin
    if (reset) begin
      timeout_code <= 8'h00;
      interval_s <= 16'h0000;
      remaining_s <= 16'h0000;
      idle_mode <= 1'b1;
      standby_mode <= 1'b0;
      spin_up_req <= 1'b0;
      spin_down_req <= 1'b0;
    end else begin
      if (load_timer) begin
        timeout_code <= sector_count;
        interval_s <= decode_timeout(sector_count);
        remaining_s <= decode_timeout(sector_count);
      end else if (enter_idle) begin
        remaining_s <= interval_s;
      end else if (timer_reload) begin
        remaining_s <= interval_s;
      end else if (timer_step) begin
        remaining_s <= remaining_s - 16'h0001;
      end
      if (enter_idle) begin
        idle_mode <= 1'b1;
        standby_mode <= 1'b0;
        spin_down_req <= 1'b0;
        spin_up_req <= !spin_sync;
      end else if (timer_expire) begin
        idle_mode <= 1'b0;
        standby_mode <= 1'b1;
        spin_down_req <= 1'b1;
        spin_up_req <= 1'b0;
      end else if (spin_sync) begin
        // request drops once the spindle reports speed
        spin_up_req <= 1'b0;
      end
    end
  end

  // interrupt status: hardware set wins over software clear
  wire [`ISG_IRQ_WIDTH-1:0] irq_events;
  wire [`ISG_IRQ_WIDTH-1:0] irq_clear;
  assign irq_events[`ISG_IRQ_DONE_BIT] = exec_now;
  assign irq_events[`ISG_IRQ_ABORT_BIT] = exec_now && cmd_reject;
  assign irq_events[`ISG_IRQ_STANDBY_BIT] = timer_expire;
  assign irq_clear = (bus_wr && bus_addr == `ISG_OFF_IRQ_STATUS) ?
                     bus_wdata[`ISG_IRQ_WIDTH-1:0] : {`ISG_IRQ_WIDTH{1'b0}};

  // one sticky bit per event
  genvar g;
  generate
    for (g = 0; g < `ISG_IRQ_WIDTH; g = g + 1) begin : gen_irq_bit
      reg sticky;
      always @(posedge core_clk) begin
        if (reset) begin
          sticky <= 1'b0;
        end else if (irq_events[g]) begin
          sticky <= 1'b1;
        end else if (irq_clear[g]) begin
          sticky <= 1'b0;
        end
      end
      assign irq_status[g] = sticky;
    end
  endgenerate

  always @(posedge core_clk) begin
    if (reset) begin
      irq_mask <= {`ISG_IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
      id_index <= 8'h00;
    end else begin
      if (bus_wr && bus_addr == `ISG_OFF_IRQ_MASK) begin
        irq_mask <= bus_wdata[`ISG_IRQ_WIDTH-1:0];
      end
      if (bus_wr && bus_addr == `ISG_OFF_ID_INDEX) begin
        id_index <= bus_wdata[7:0];
      end
      // one cycle behind the status bits so the output stays a flop
      irq <= |(irq_status & irq_mask);
    end
  end

  // identify words built from the stored geometry
  // at most fffh x 16 x 255, so the 32-bit product never wraps
  wire [31:0] capacity = {16'h0000, `ISG_CUR_CYLS} *
                         {24'h000000, 4'h0, heads_minus_one} +
                         {16'h0000, `ISG_CUR_CYLS} *
                         32'h00000001;
  wire [31:0] capacity_sectors;
  assign capacity_sectors = capacity * {24'h000000, sectors_per_track};
  reg [15:0] id_word;

  always @* begin
    id_word = 16'h0000;
    if (id_index == `ISG_ID_WORD_CYLS) begin
      id_word = `ISG_CUR_CYLS;
    end else if (id_index == `ISG_ID_WORD_HEADS) begin
      id_word = {11'h000, {1'b0, heads_minus_one} + 5'h01};
    end else if (id_index == `ISG_ID_WORD_SPT) begin
      id_word = {8'h00, sectors_per_track};
    end else if (id_index == `ISG_ID_WORD_CAP_LO) begin
      id_word = capacity_sectors[15:0];
    end else if (id_index == `ISG_ID_WORD_CAP_HI) begin
      id_word = capacity_sectors[31:16];
    end
  end

  // read data, valid in the cycle after the strobe; unmapped reads zero
  reg [31:0] next_rdata;
  wire [7:0] status_byte = {busy, !busy, 1'b0, spin_sync, 1'b0, 1'b0, 1'b0, err};

  always @* begin
    next_rdata = 32'h00000000;
    if (bus_addr == `ISG_OFF_SECCNT) begin
      next_rdata = {24'h000000, sector_count};
    end else if (bus_addr == `ISG_OFF_DEVHEAD) begin
      next_rdata = {24'h000000, device_head};
    end else if (bus_addr == `ISG_OFF_COMMAND) begin
      next_rdata = {24'h000000, command};
    end else if (bus_addr == `ISG_OFF_ERROR) begin
      next_rdata = {29'h00000000, command_aborted_flag, 2'b00};
    end else if (bus_addr == `ISG_OFF_STATUS) begin
      next_rdata = {24'h000000, status_byte};
    end else if (bus_addr == `ISG_OFF_GEOMETRY) begin
      next_rdata = {20'h00000, heads_minus_one, sectors_per_track};
    end else if (bus_addr == `ISG_OFF_TIMER) begin
      next_rdata = {remaining_s, 8'h00, timeout_code};
    end else if (bus_addr == `ISG_OFF_IRQ_STATUS) begin
      next_rdata = {29'h00000000, irq_status};
    end else if (bus_addr == `ISG_OFF_IRQ_MASK) begin
      next_rdata = {29'h00000000, irq_mask};
    end else if (bus_addr == `ISG_OFF_DEFAULTS) begin
      next_rdata = {24'h000000, defaults_option};
    end else if (bus_addr == `ISG_OFF_POWER) begin
      next_rdata = {28'h0000000, spin_down_req, spin_up_req, standby_mode, idle_mode};
    end else if (bus_addr == `ISG_OFF_ID_INDEX) begin
      next_rdata = {24'h000000, id_index};
    end else if (bus_addr == `ISG_OFF_ID_DATA) begin
      next_rdata = {16'h0000, id_word};
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

endmodule

// file: isg_checker.sv
// port-level assertions for the idle, standby timer and geometry block
`timescale 1ns/1ps
`include "isg_defs.vh"
module isg_checker (
  input wire core_clk,
  input wire reset,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire spindle_rotating,
  input wire soft_reset,
  input wire spin_up_req,
  input wire spin_down_req,
  input wire idle_mode,
  input wire standby_mode,
  input wire irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire cmd_wr = bus_wr && (bus_addr == `ISG_OFF_COMMAND);
  a_rdata_idle_zero:
    assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_modes_exclusive:
    assert property (!(idle_mode && standby_mode))
    else $error("idle and standby both set");
  a_spin_down_standby:
    assert property (spin_down_req |-> standby_mode)
    else $error("spin down outside standby");
  a_spin_up_idle:
    assert property (spin_up_req |-> idle_mode)
    else $error("spin up outside idle");
  a_spin_up_stops:
    assert property (spindle_rotating [*4] |=> !spin_up_req)
    else $error("spin up held while spindle rotating");
  a_idle_imm_enters:
    assert property (cmd_wr && bus_wdata[7:0] == `ISG_CMD_IDLE_IMM_A && !$past(bus_wr)
      |-> ##2 idle_mode && !standby_mode)
    else $error("idle immediate did not enter idle");
  a_standby_exit_cmd:
    assert property ($fell(standby_mode) |-> $past(cmd_wr, 2) || $past(cmd_wr, 3))
    else $error("standby left without command");
  a_standby_from_idle:
    assert property ($rose(standby_mode) |-> $past(idle_mode))
    else $error("standby entered not from idle");
  a_irq_fall_write:
    assert property ($fell(irq) |-> $past(bus_wr, 2) || $past(bus_wr, 3))
    else $error("interrupt dropped without a write");
  c_standby: cover property ($rose(standby_mode));
  c_irq: cover property ($rose(irq));
  c_spin_up: cover property ($rose(spin_up_req));
endmodule

bind isg_cmd_block isg_checker u_chk (.core_clk(core_clk), .reset(reset),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .spindle_rotating(spindle_rotating), .soft_reset(soft_reset),
  .spin_up_req(spin_up_req), .spin_down_req(spin_down_req), .idle_mode(idle_mode),
  .standby_mode(standby_mode), .irq(irq));

// file: isg_spindle_model.sv
// spindle motor model: slow spin-up on request, stops on spin-down request
`timescale 1ns/1ps
module isg_spindle_model #(
  parameter int SPIN_UP_CYCLES = 20
) (
  input wire core_clk,
  input wire spin_up_req,
  input wire spin_down_req,
  output logic spindle_rotating
);
  int cnt = 0;
  initial spindle_rotating = 1'b1;
  always @(posedge core_clk) begin
    if (spin_down_req) begin
      spindle_rotating <= 1'b0;
      cnt <= 0;
    end else if (spin_up_req && !spindle_rotating) begin
      // takes time to reach speed so a held request is really observable
      cnt <= cnt + 1;
      if (cnt == SPIN_UP_CYCLES) spindle_rotating <= 1'b1;
    end
  end
endmodule

// file: testbench.sv
// self-checking bench for the idle, standby timer and geometry commands
`timescale 1ns/1ps
`include "isg_defs.vh"
module testbench;
  logic core_clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, soft_reset = 0;
  logic [7:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0;
  wire [31:0] bus_rdata;
  wire spindle_rotating, spin_up_req, spin_down_req, idle_mode, standby_mode, irq;
  int errors = 0, checks = 0, i;
  logic [31:0] d;
  logic [7:0] codes [6] = '{8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
  initial forever #20 core_clk = ~core_clk;
  isg_cmd_block #(.SEC_CYCLES(25'h00000a)) u_dut (.core_clk(core_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .spindle_rotating(spindle_rotating), .soft_reset(soft_reset),
    .spin_up_req(spin_up_req), .spin_down_req(spin_down_req), .idle_mode(idle_mode),
    .standby_mode(standby_mode), .irq(irq));
  isg_spindle_model u_spin (.core_clk(core_clk), .spin_up_req(spin_up_req),
    .spin_down_req(spin_down_req), .spindle_rotating(spindle_rotating));
  function automatic logic [15:0] secs_of(input logic [7:0] c);
    if (c <= 8'hf0) return c * 16'h0005;
    if (c <= 8'hfb) return (c - 8'hf0) * 16'h0708;
    if (c == 8'hfc) return 16'h04ec;
    if (c == 8'hfd) return 16'h7080;
    return 16'h04fb;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      bad("wait ran out");
      tally_and_finish();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    checks++;
    if (d !== e) bad($sformatf("reg %h got %h expected %h", a, d, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) bad("pin level");
  endtask
  task automatic rt(input logic [7:0] c);
    logic [15:0] s;
    s = secs_of(c);
    rd(`ISG_OFF_TIMER);
    checks++;
    // a second tick may land between load and read
    if (d[7:0] !== c || (d[31:16] !== s && d[31:16] !== s - 16'h1)) bad("timer field");
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(`ISG_OFF_COMMAND, {24'h0, c});
    tick(2);
  endtask
  task automatic idle(input logic [7:0] t, input logic [7:0] op);
    wr(`ISG_OFF_SECCNT, {24'h0, t});
    cmd(op);
  endtask
  task automatic pulse_soft;
    @(posedge core_clk);
    soft_reset <= 1'b1;
    tick(4);
    @(posedge core_clk);
    soft_reset <= 1'b0;
    tick(6);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    rc(`ISG_OFF_GEOMETRY, 32'h00000f3f);
    rc(`ISG_OFF_DEFAULTS, 32'h00000066);
    rc(`ISG_OFF_POWER, 32'h00000001);
    rc(`ISG_OFF_STATUS, 32'h00000050);
    rc(8'h3c, 32'h0);
    wr(`ISG_OFF_GEOMETRY, 32'h0);
    rc(`ISG_OFF_GEOMETRY, 32'h00000f3f);
    $display("test reset values done");
    for (i = 0; i < 6; i++) begin
      idle(codes[i], i[0] ? `ISG_CMD_IDLE_B : `ISG_CMD_IDLE_A);
      rt(codes[i]);
    end
    chk1(spin_up_req, 1'b0);
    cmd(`ISG_CMD_IDLE_IMM_A);
    rt(8'hff);
    cmd(`ISG_CMD_IDLE_IMM_B);
    rt(8'hff);
    wr(`ISG_OFF_IRQ_STATUS, 32'h7);
    idle(8'hfe, `ISG_CMD_IDLE_A);
    rc(`ISG_OFF_ERROR, 32'h4);
    rc(`ISG_OFF_STATUS, 32'h51);
    rc(`ISG_OFF_IRQ_STATUS, 32'h3);
    rt(8'hff);
    cmd(8'h00);
    rc(`ISG_OFF_ERROR, 32'h4);
    $display("test timeout codes done");
    idle(8'h00, `ISG_CMD_IDLE_A);
    tick(80);
    chk1(standby_mode, 1'b0);
    idle(8'h02, `ISG_CMD_IDLE_B);
    repeat (3) begin
      tick(60);
      rc(`ISG_OFF_STATUS, 32'h50);
      chk1(standby_mode, 1'b0);
    end
    wr(`ISG_OFF_IRQ_STATUS, 32'h7);
    idle(8'h01, `ISG_CMD_IDLE_A);
    rt(8'h01);
    tick(30);
    chk1(standby_mode, 1'b0);
    for (i = 0; i < 60 && standby_mode !== 1'b1; i++) tick(1);
    tmo(standby_mode);
    chk1(spin_down_req, 1'b1);
    rc(`ISG_OFF_POWER, 32'ha);
    rc(`ISG_OFF_IRQ_STATUS, 32'h5);
    tick(4);
    cmd(`ISG_CMD_IDLE_IMM_A);
    chk1(idle_mode, 1'b1);
    chk1(spin_up_req, 1'b1);
    for (i = 0; i < 40 && spin_up_req !== 1'b0; i++) tick(1);
    tmo(!spin_up_req);
    rc(`ISG_OFF_STATUS, 32'h50);
    idle(8'h00, `ISG_CMD_IDLE_A);
    $display("test standby timer done");
    wr(`ISG_OFF_SECCNT, 32'h0);
    wr(`ISG_OFF_DEVHEAD, 32'ha5);
    cmd(`ISG_CMD_INIT_PARAMS);
    rc(`ISG_OFF_GEOMETRY, 32'h500);
    wr(`ISG_OFF_ID_INDEX, 32'h38);
    rc(`ISG_OFF_ID_DATA, 32'h0);
    wr(`ISG_OFF_ID_INDEX, 32'h36);
    rc(`ISG_OFF_ID_DATA, 32'hfff);
    pulse_soft();
    rc(`ISG_OFF_GEOMETRY, 32'h500);
    wr(`ISG_OFF_DEFAULTS, 32'hcc);
    pulse_soft();
    rc(`ISG_OFF_GEOMETRY, 32'hf3f);
    wr(`ISG_OFF_SECCNT, 32'h11);
    wr(`ISG_OFF_DEVHEAD, 32'h03);
    cmd(`ISG_CMD_INIT_PARAMS);
    rc(`ISG_OFF_GEOMETRY, 32'h311);
    wr(`ISG_OFF_ID_INDEX, 32'h37);
    rc(`ISG_OFF_ID_DATA, 32'h4);
    wr(`ISG_OFF_ID_INDEX, 32'h39);
    rc(`ISG_OFF_ID_DATA, 32'h3fbc);
    wr(`ISG_OFF_ID_INDEX, 32'h3a);
    rc(`ISG_OFF_ID_DATA, 32'h4);
    $display("test geometry done");
    wr(`ISG_OFF_IRQ_STATUS, 32'h7);
    wr(`ISG_OFF_IRQ_MASK, 32'h1);
    cmd(`ISG_CMD_IDLE_IMM_A);
    tick(2);
    chk1(irq, 1'b1);
    wr(`ISG_OFF_IRQ_STATUS, 32'h1);
    tick(2);
    chk1(irq, 1'b0);
    wr(`ISG_OFF_IRQ_MASK, 32'h0);
    cmd(`ISG_CMD_IDLE_IMM_A);
    tick(2);
    chk1(irq, 1'b0);
    rc(`ISG_OFF_IRQ_STATUS, 32'h1);
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule
